/* dv/tcb_chk.sv */
/* assertions on the ports of tcb_timer.
 assumes one clock domain and the async active-high reset. */
`timescale 1ns/100ps
module tcb_chk (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // controls and writes
   input wire logic timer_run,
   input wire logic sync_disable,
   input wire logic sleep_mode,
   input wire logic rollover_irq_enable,
   input wire logic peripheral_irq_enable,
   input wire logic global_irq_enable,
   input wire tcb_pkg::tcb_mode_t capcmp_mode,
   input wire logic [7:0] wdata,
   input wire logic count_low_byte_we,
   input wire logic count_high_byte_we,
   input wire logic rollover_flag_we,
   // status
   input wire logic [7:0] count_low_byte,
   input wire logic [7:0] count_high_byte,
   input wire logic rollover_flag,
   input wire logic rollover_irq,
   input wire logic capcmp_event,
   input wire logic wake,
   input wire logic vector_req
);
   import tcb_pkg::*;
   wire [15:0] cnt = {count_high_byte, count_low_byte};
   wire cw = count_low_byte_we | count_high_byte_we;
   wire nap = sleep_mode & ~sync_disable;
   wire en_all = timer_run & rollover_irq_enable & peripheral_irq_enable
      & global_irq_enable;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   sequence s_top;
      cnt == 16'hffff && !cw && !capcmp_event;
   endsequence
   // one cycle to enter sleep, then the count must freeze
   sequence s_nap;
      nap ##1 nap && !cw && !capcmp_event;
   endsequence
   property p_wrap; s_top ##1 cnt == 16'h0000 |-> rollover_flag; endproperty
   a_wrap: assert property (p_wrap) else $error("no flag on wrap");
   property p_hold; !timer_run && !cw && !capcmp_event |=> $stable(cnt);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved");
   property p_nap; s_nap |=> $stable(cnt); endproperty
   a_nap: assert property (p_nap) else $error("count in sleep");
   property p_irq; rollover_irq == (rollover_flag && en_all); endproperty
   a_irq: assert property (p_irq) else $error("irq gating");
   property p_keep; rollover_flag && !rollover_flag_we |=> rollover_flag;
   endproperty
   a_keep: assert property (p_keep) else $error("flag dropped");
   property p_wr; count_low_byte_we |=> count_low_byte == $past(wdata);
   endproperty
   a_wr: assert property (p_wr) else $error("write lost");
   property p_clear;
      capcmp_event && capcmp_mode == TCB_MODE_SPECIAL && !cw
         |=> cnt == 16'h0000;
   endproperty
   a_clear: assert property (p_clear) else $error("no clear");
   property p_wake;
      wake |-> rollover_flag && vector_req == global_irq_enable;
   endproperty
   a_wake: assert property (p_wake) else $error("bad wake");
endmodule
bind tcb_timer tcb_chk u_tcb_chk (.*);

/* dv/tcb_ticker.sv */
/* far-side tick source standing for the cpu clock and oscillators.
 assumes clk_sys from the bench. */
`timescale 1ns/100ps
module tcb_ticker (
   // clock and enable
   input wire logic clk_sys,
   input wire logic en,
   // tick level
   output logic tick
);
   initial tick = 1'b0;
   // a rising tick every second cycle; held low while off
   always @(posedge clk_sys) tick <= en ? ~tick : 1'b0;
endmodule

/* dv/tcb_timer_test.sv */
/* self-checking bench for tcb_timer.
 assumes tcb_ticker as tick source and tcb_chk bound in. */
`timescale 1ns/100ps
module tcb_timer_test;
   import tcb_pkg::*;
   logic clk_sys, rst, timer_run, sync_disable, secondary_osc_enable;
   logic rollover_irq_enable, peripheral_irq_enable, global_irq_enable;
   logic count_low_byte_we, count_high_byte_we, rollover_flag_we;
   logic capcmp_value_low_we, capcmp_value_high_we, capture_event;
   logic sleep_mode, instr_tick, ext_clk, sosc_clk, tick_en;
   logic rollover_flag, rollover_irq, capcmp_event, sosc_running;
   logic wake, vector_req;
   logic [1:0] clock_source_select;
   logic [4:0] we;
   logic [7:0] wdata, count_low_byte, count_high_byte;
   logic [7:0] capcmp_value_low, capcmp_value_high;
   tcb_mode_t capcmp_mode;
   int error_cnt, n_compared, i;
   wire [15:0] cnt = {count_high_byte, count_low_byte};
   assign {capcmp_value_high_we, capcmp_value_low_we, rollover_flag_we,
      count_high_byte_we, count_low_byte_we} = we;
   assign ext_clk = instr_tick;
   // the secondary tick stands still while its oscillator is off
   assign sosc_clk = instr_tick & secondary_osc_enable;
   tcb_timer u_tcb_timer (.*);
   tcb_ticker u_tcb_ticker (.clk_sys(clk_sys), .en(tick_en),
      .tick(instr_tick));
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic cyc(input int n);
      we = 5'h00;
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // strobes stay up until the next cyc, so writes may run back to back
   task automatic wr(input logic [4:0] s, input logic [7:0] d);
      we = s;
      wdata = d;
      @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #40000;
      error_cnt++;
      wrap_up;
   end
   initial begin
      rst = 1'b1;
      {timer_run, sync_disable, secondary_osc_enable, tick_en} = 4'h0;
      {rollover_irq_enable, peripheral_irq_enable, global_irq_enable} = 3'h0;
      {sleep_mode, capture_event, we, wdata} = 15'h0000;
      clock_source_select = TCB_CLK_INSTR;
      capcmp_mode = TCB_MODE_OFF;
      {error_cnt, n_compared} = 0;
      repeat (3) @(posedge clk_sys);
      #1 rst = 1'b0;
      tick_en = 1'b1;
      cyc(10);
      chk(cnt, 16'h0000);
      chk(sosc_running, 1'b0);
      wr(5'h03, 8'hff);
      wr(5'h04, 8'h00);
      timer_run = 1'b1;
      for (i = 0; i < 8 && rollover_flag !== 1'b1; i++) cyc(1);
      chk(cnt, 16'h0000);
      chk(rollover_flag, 1'b1);
      for (i = 0; i < 16; i++) begin
         {timer_run, rollover_irq_enable, peripheral_irq_enable,
            global_irq_enable} = i[3:0];
         #1 chk(rollover_irq, i == 15);
         cyc(1);
      end
      cyc(6);
      chk(rollover_flag, 1'b1);
      wr(5'h04, 8'hfe);
      chk(rollover_flag, 1'b0);
      timer_run = 1'b0;
      capcmp_mode = TCB_MODE_CAPTURE;
      wr(5'h01, 8'h34);
      wr(5'h02, 8'h12);
      cyc(1);
      capture_event = 1'b1;
      cyc(1);
      capture_event = 1'b0;
      chk({capcmp_value_high, capcmp_value_low}, 16'h1234);
      // plain compare: one event per match and the count is left alone
      capcmp_mode = TCB_MODE_COMPARE;
      #1 chk(capcmp_event, 1'b1);
      cyc(1);
      chk(capcmp_event, 1'b0);
      chk(cnt, 16'h1234);
      // synchronous instruction tick kept for the special trigger
      capcmp_mode = TCB_MODE_SPECIAL;
      wr(5'h08, 8'h05);
      wr(5'h10, 8'h00);
      wr(5'h03, 8'h00);
      cyc(1);
      timer_run = 1'b1;
      repeat (2) begin
         for (i = 0; i < 20 && capcmp_event !== 1'b1; i++) cyc(1);
         chk(cnt, 16'h0005);
         cyc(1);
         chk(cnt, 16'h0000);
      end
      chk(rollover_flag, 1'b0);
      timer_run = 1'b0;
      wr(5'h01, 8'h05);
      wr(5'h01, 8'h09);
      chk(cnt, 16'h0009);
      capcmp_mode = TCB_MODE_OFF;
      wr(5'h03, 8'hff);
      sleep_mode = 1'b1;
      // external source but synchronous: still frozen in sleep
      clock_source_select = TCB_CLK_EXT;
      cyc(2);
      timer_run = 1'b1;
      cyc(10);
      chk(cnt, 16'hffff);
      secondary_osc_enable = 1'b1;
      cyc(1);
      chk(sosc_running, 1'b1);
      sync_disable = 1'b1;
      clock_source_select = TCB_CLK_SOSC;
      for (i = 0; i < 12 && wake !== 1'b1; i++) cyc(1);
      chk(wake, 1'b1);
      chk(vector_req, 1'b1);
      chk(sosc_running, 1'b1);
      // the woken cpu leaves sleep; holding sleep_mode past the wake
      // would make the one run cycle look like counting while asleep
      sleep_mode = 1'b0;
      cyc(2);
      wrap_up;
   end
endmodule

/* verilog/tcb_capcmp.sv */
/*
 capture/compare value pair: capture copy, compare match, special event.
 assumes the count and capture event are synchronous to clk_sys.
*/
`timescale 1ns/100ps
module tcb_capcmp (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // configuration
   input wire tcb_pkg::tcb_mode_t mode,
   input wire logic capture_event,
   // software access to value pair
   input wire logic [7:0] capcmp_wdata,
   input wire logic capcmp_value_low_we,
   input wire logic capcmp_value_high_we,
   // time base
   input wire logic [15:0] count,
   // results
   output logic [7:0] capcmp_value_low,
   output logic [7:0] capcmp_value_high,
   output logic match_pulse,
   output logic special_clear
);
   import tcb_pkg::*;
   logic [15:0] val_q;
   logic [15:0] val_d;
   logic hit_q;
   logic hit_d;
   logic hit_now;
   always_comb begin
      val_d = val_q;
      if (mode == TCB_MODE_CAPTURE && capture_event) begin
         val_d = count;
      end
      if (capcmp_value_low_we) begin
         val_d[TCB_LO_LSB +: TCB_BYTE_W] = capcmp_wdata;
      end
      if (capcmp_value_high_we) begin
         val_d[TCB_HI_LSB +: TCB_BYTE_W] = capcmp_wdata;
      end
   end
   // match is edge qualified so a held equal value fires once
   assign hit_now = (mode == TCB_MODE_COMPARE || mode == TCB_MODE_SPECIAL)
      && (count == val_q);
   always_comb begin
      hit_d = hit_now;
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         val_q <= TCB_CNT_RST;
         hit_q <= 1'b0;
      end else begin
         val_q <= val_d;
         hit_q <= hit_d;
      end
   end
   assign match_pulse = hit_now & ~hit_q;
   // value pair acts as the period in special event mode
   assign special_clear = match_pulse && mode == TCB_MODE_SPECIAL;
   assign capcmp_value_low = val_q[TCB_LO_LSB +: TCB_BYTE_W];
   assign capcmp_value_high = val_q[TCB_HI_LSB +: TCB_BYTE_W];
endmodule

/* verilog/tcb_edge.sv */
/*
 edge picker: turns a synchronous tick level into a one-cycle step pulse.
 assumes the tick input is already synchronous to clk_sys.
*/
`timescale 1ns/100ps
module tcb_edge (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // tick in, pulse out
   input wire logic tick_in,
   output logic step_out
);
   import tcb_pkg::*;
   logic prev_q;
   logic prev_d;
   always_comb begin
      prev_d = tick_in;
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
      end
   end
   assign step_out = tick_in & ~prev_q;
endmodule

/* verilog/tcb_pkg.sv */
/*
 package for the 16-bit rollover timer with capture/compare time base:
 widths, reset values, state encodings and compare modes.
 assumes nothing of its surroundings.
*/
package tcb_pkg;
   localparam int TCB_W = 16;
   localparam logic [15:0] TCB_CNT_RST = 16'h0000;
   localparam logic [15:0] TCB_CNT_MAX = 16'hffff;
   localparam int TCB_BYTE_W = 8;
   localparam int TCB_LO_LSB = 0;
   localparam int TCB_HI_LSB = 8;
   // clock source selection
   localparam logic [1:0] TCB_CLK_INSTR = 2'h0;
   localparam logic [1:0] TCB_CLK_EXT = 2'h1;
   localparam logic [1:0] TCB_CLK_SOSC = 2'h2;
   // capture/compare unit modes
   typedef enum logic [3:0] {
      TCB_MODE_OFF = 4'h1,
      TCB_MODE_CAPTURE = 4'h2,
      TCB_MODE_COMPARE = 4'h4,
      TCB_MODE_SPECIAL = 4'h8
   } tcb_mode_t;
   // power states for sleep and wake
   typedef enum logic [2:0] {
      TCB_RUN = 3'h1,
      TCB_SLEEP = 3'h2,
      TCB_WAKE = 3'h4
   } tcb_pwr_t;
endpackage

/* verilog/tcb_timer.sv */
/*
 16-bit rollover timer with interrupt gating, sleep wake and a
 capture/compare time base.
 assumes all inputs synchronous to clk_sys; external and secondary clock
 ticks arrive as levels sampled here, the cpu drives sleep_mode.
*/
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Contract
// - count up in two bytes, wrap from ffff to 0000
// - set rollover flag on every wrap from maximum to zero
// - request interrupt only with run, rollover, peripheral, global enables
// - flag holds until software writes it to zero
// - count in sleep only in async mode from external or secondary source
// - overflow in sleep wakes if rollover and peripheral enables set; vector to service if global enable set
// - secondary oscillator keeps running in sleep regardless of sync bit
// - capture mode copies count into value pair on capture event
// - compare mode raises event when value pair equals count
// - special event trigger clears both counter bytes
// - special event trigger never sets the rollover flag
// - value pair acts as timer period in special event mode
// - counter byte write beats a coincident special event clear
module tcb_timer (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // timer control
   input wire logic timer_run,
   input wire logic sync_disable,
   input wire logic [1:0] clock_source_select,
   input wire logic secondary_osc_enable,
   // clock ticks
   input wire logic instr_tick,
   input wire logic ext_clk,
   input wire logic sosc_clk,
   // interrupt enables
   input wire logic rollover_irq_enable,
   input wire logic peripheral_irq_enable,
   input wire logic global_irq_enable,
   // software writes
   input wire logic [7:0] wdata,
   input wire logic count_low_byte_we,
   input wire logic count_high_byte_we,
   input wire logic rollover_flag_we,
   input wire logic capcmp_value_low_we,
   input wire logic capcmp_value_high_we,
   // capture/compare unit
   input wire tcb_pkg::tcb_mode_t capcmp_mode,
   input wire logic capture_event,
   // power
   input wire logic sleep_mode,
   // status
   output logic [7:0] count_low_byte,
   output logic [7:0] count_high_byte,
   output logic rollover_flag,
   output logic rollover_irq,
   output logic [7:0] capcmp_value_low,
   output logic [7:0] capcmp_value_high,
   output logic capcmp_event,
   output logic sosc_running,
   output logic wake,
   output logic vector_req
);
   import tcb_pkg::*;
   ////////////////////////////////////////////////////////////////////////
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic flag_q;
   logic flag_d;
   tcb_pwr_t pwr_q;
   tcb_pwr_t pwr_d;
   logic src_level;
   logic src_step;
   logic async_ok;
   logic may_count;
   logic inc;
   logic wrap;
   logic sp_clear;
   logic sw_write;
   logic [15:0] cnt_plus;
   logic [16:0] carry;
   logic [1:0] lane_we;
   logic [15:0] cnt_wr;
   logic [1:0] sel_q;
   logic [1:0] sel_d;
   logic sel_moved;
   logic step_ok;
   ////////////////////////////////////////////////////////////////////////
   // clock source selection; the secondary oscillator stays up in sleep
   // whatever the sync setting, only its enable stops it
   assign sosc_running = secondary_osc_enable;
   always_comb begin
      if (clock_source_select == TCB_CLK_EXT) begin
         src_level = ext_clk;
      end else if (clock_source_select == TCB_CLK_SOSC) begin
         src_level = sosc_clk & secondary_osc_enable;
      end else begin
         src_level = instr_tick;
      end
   end
   tcb_edge u_edge (
      .clk_sys(clk_sys),
      .rst(rst),
      .tick_in(src_level),
      .step_out(src_step)
   );
   // the mux can show a rising level the moment the source changes; that
   // is a tick of neither clock, so a step in that cycle is dropped
   always_comb begin
      sel_d = clock_source_select;
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sel_q <= TCB_CLK_INSTR;
      end else begin
         sel_q <= sel_d;
      end
   end
   assign sel_moved = sel_q != clock_source_select;
   assign step_ok = src_step && !sel_moved;
   // in sleep only asynchronous counting from the external or secondary source survives
   assign async_ok = sync_disable && clock_source_select != TCB_CLK_INSTR;
   assign may_count = (pwr_q != TCB_SLEEP) || async_ok;
   assign inc = timer_run && step_ok && may_count;
   // ripple carry per bit; the carry out of the top bit is the wrap
   assign carry[0] = 1'b1;
   for (genvar b = 0; b < TCB_W; b++) begin : g_inc
      assign cnt_plus[b] = cnt_q[b] ^ carry[b];
      assign carry[b + 1] = carry[b] & cnt_q[b];
   end
   assign wrap = inc && carry[TCB_W];
   assign sw_write = count_low_byte_we | count_high_byte_we;
   // one write lane per counter byte
   assign lane_we = {count_high_byte_we, count_low_byte_we};
   for (genvar l = 0; l < TCB_W / TCB_BYTE_W; l++) begin : g_lane
      assign cnt_wr[l * TCB_BYTE_W +: TCB_BYTE_W] = lane_we[l] ? wdata
         : cnt_q[l * TCB_BYTE_W +: TCB_BYTE_W];
   end
   ////////////////////////////////////////////////////////////////////////
   tcb_capcmp u_capcmp (
      .clk_sys(clk_sys),
      .rst(rst),
      .mode(capcmp_mode),
      .capture_event(capture_event),
      .capcmp_wdata(wdata),
      .capcmp_value_low_we(capcmp_value_low_we),
      .capcmp_value_high_we(capcmp_value_high_we),
      .count(cnt_q),
      .capcmp_value_low(capcmp_value_low),
      .capcmp_value_high(capcmp_value_high),
      .match_pulse(capcmp_event),
      .special_clear(sp_clear)
   );
   ////////////////////////////////////////////////////////////////////////
   // counter: write beats special clear beats increment
   always_comb begin
      cnt_d = cnt_q;
      if (inc) begin
         cnt_d = cnt_plus;
      end
      if (sp_clear) begin
         cnt_d = TCB_CNT_RST;
      end
      if (sw_write) begin
         cnt_d = cnt_wr;
      end
   end
   // flag: hardware set wins over a software clear in the same cycle;
   // the special event clear is not a wrap and never sets it
   always_comb begin
      flag_d = flag_q;
      if (rollover_flag_we) begin
         flag_d = wdata[0];
      end
      if (wrap && !sp_clear && !sw_write) begin
         flag_d = 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // sleep and wake sequencing
   always_comb begin
      pwr_d = pwr_q;
      case (pwr_q)
         TCB_RUN: begin
            if (sleep_mode) begin
               pwr_d = TCB_SLEEP;
            end
         end
         TCB_SLEEP: begin
            if (wrap && timer_run && rollover_irq_enable
                  && peripheral_irq_enable) begin
               pwr_d = TCB_WAKE;
            end else if (!sleep_mode) begin
               pwr_d = TCB_RUN;
            end
         end
         TCB_WAKE: begin
            pwr_d = TCB_RUN;
         end
         default: begin
            pwr_d = TCB_RUN;
         end
      endcase
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_q <= TCB_CNT_RST;
         flag_q <= 1'b0;
         pwr_q <= TCB_RUN;
      end else begin
         cnt_q <= cnt_d;
         flag_q <= flag_d;
         pwr_q <= pwr_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   assign count_low_byte = cnt_q[TCB_LO_LSB +: TCB_BYTE_W];
   assign count_high_byte = cnt_q[TCB_HI_LSB +: TCB_BYTE_W];
   assign rollover_flag = flag_q;
   assign rollover_irq = flag_q && timer_run && rollover_irq_enable
      && peripheral_irq_enable && global_irq_enable;
   // wake resumes the next instruction; vectoring needs the global enable
   assign wake = pwr_q == TCB_WAKE;
   assign vector_req = wake && global_irq_enable;
endmodule
